/* logic/serial_port_pkg.sv */
// Constants shared by the remote serial command port.
// Assumes a 40 MHz system clock.
package serial_port_pkg;
  localparam int unsigned CLK_HZ    = 40000000;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  // Baud selection codes.
  localparam logic [2:0] BAUD_1200   = 3'h0;
  localparam logic [2:0] BAUD_9600   = 3'h1;
  localparam logic [2:0] BAUD_38400  = 3'h2;
  localparam logic [2:0] BAUD_57600  = 3'h3;
  localparam logic [2:0] BAUD_115200 = 3'h4;
  localparam int unsigned DIV_1200   = CLK_HZ / 1200;
  localparam int unsigned DIV_9600   = CLK_HZ / 9600;
  localparam int unsigned DIV_38400  = CLK_HZ / 38400;
  localparam int unsigned DIV_57600  = CLK_HZ / 57600;
  localparam int unsigned DIV_115200 = CLK_HZ / 115200;
  // Terminator selection codes; reset value is line feed alone.
  localparam logic [1:0] TERM_LF    = 2'h0;
  localparam logic [1:0] TERM_CR    = 2'h1;
  localparam logic [1:0] TERM_CRLF  = 2'h2;
  localparam logic [1:0] TERM_RESET = TERM_LF;
  localparam logic       IF_RS232   = 1'b0;
  localparam logic       IF_USB     = 1'b1;
endpackage : serial_port_pkg

/* logic/remote_serial_command_port.sv */
// Serial front end of the remote-control port: receive, transmit with
// terminator insertion, line-end detection and keyboard lock.
// Assumes all inputs synchronous to clk; the serial lines idle high.
// Notes on behaviour
// R1 - 8 data bits, one stop, no parity
// R2 - Five selectable baud rates, both directions
// R3 - Exactly one interface, RS-232 or USB, active
// R4 - Line activity starts traffic and locks keyboard
// R5 - Terminator resets to line feed
// R6 - Terminator is LF, CR, or CR then LF
// R7 - Responses end with the configured terminator
// R8 - Host closes each command with the terminator
// R9 - Host uses the same rate and stop bits
// R10 - Low start bit, data sent LSB first
module remote_serial_command_port
  import serial_port_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] baud_sel,
  input  wire logic       remote_sel,
  input  wire logic       term_wr,
  input  wire logic [1:0] term_sel,
  input  wire logic       rs232_rxd,
  output logic            rs232_txd,
  input  wire logic       usb_rxd,
  output logic            usb_txd,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_line_end,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [1:0]      line_terminator,
  output logic            key_lock,
  output logic            rx_frame_err
);
  // The buffer logic below is written for exactly two entries.
  if (BUF_DEPTH != 2) begin : g_depth_check
    $error("BUF_DEPTH must be 2");
  end

  typedef enum {IDLE, START, DATA, STOP} phase_t;

  logic [15:0] bit_div;
  always_comb begin
    unique case (baud_sel) // R2
      BAUD_1200:   bit_div = 16'(DIV_1200);
      BAUD_9600:   bit_div = 16'(DIV_9600);
      BAUD_38400:  bit_div = 16'(DIV_38400);
      BAUD_57600:  bit_div = 16'(DIV_57600);
      default:     bit_div = 16'(DIV_115200);
    endcase
  end

  // Only the selected line is listened to; the other transmitter idles.
  logic rxd;
  logic txd;
  assign rxd       = (remote_sel == IF_USB) ? usb_rxd : rs232_rxd; // R3
  assign rs232_txd = (remote_sel == IF_RS232) ? txd : 1'b1; // R3
  assign usb_txd   = (remote_sel == IF_USB) ? txd : 1'b1; // R3

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_terminator <= TERM_RESET; // R5
    end else if (term_wr && term_sel != 2'h3) begin
      line_terminator <= term_sel; // R6
    end
  end

  // Any low level on the chosen line locks the keyboard until reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_lock <= 1'b0;
    end else if (!rxd) begin
      key_lock <= 1'b1; // R4
    end
  end

  // Receiver: samples mid-bit.
  phase_t      rx_ph;
  logic [15:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_cr_seen;
  logic        buf_full;
  logic        buf_wr;
  logic [7:0]  buf_d;
  logic        buf_end;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ph        <= IDLE;
      rx_cnt       <= 16'h0000;
      rx_bit       <= 3'h0;
      rx_sh        <= 8'h00;
      rx_frame_err <= 1'b0;
      rx_cr_seen   <= 1'b0;
      buf_wr       <= 1'b0;
      buf_d        <= 8'h00;
      buf_end      <= 1'b0;
    end else begin
      buf_wr <= 1'b0;
      unique case (rx_ph)
        IDLE: if (!rxd) begin // R10
          rx_ph  <= START;
          rx_cnt <= {1'b0, bit_div[15:1]};
        end
        START: if (rx_cnt == 16'h0000) begin
          rx_ph  <= rxd ? IDLE : DATA;
          rx_cnt <= bit_div;
          rx_bit <= 3'h0;
        end else rx_cnt <= rx_cnt - 16'h0001;
        DATA: if (rx_cnt == 16'h0000) begin
          rx_sh  <= {rxd, rx_sh[7:1]}; // R10
          rx_cnt <= bit_div;
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == 3'(DATA_BITS - 1)) rx_ph <= STOP; // R1
        end else rx_cnt <= rx_cnt - 16'h0001;
        STOP: if (rx_cnt == 16'h0000) begin
          rx_ph        <= IDLE;
          rx_frame_err <= !rxd; // R1
          // A character arriving with a full buffer is dropped.
          if (rxd && !buf_full) begin
            buf_wr <= 1'b1;
            buf_d  <= rx_sh;
            unique case (line_terminator) // R8
              TERM_LF: buf_end <= (rx_sh == CHAR_LF);
              TERM_CR: buf_end <= (rx_sh == CHAR_CR);
              default: buf_end <= rx_cr_seen && (rx_sh == CHAR_LF);
            endcase
            rx_cr_seen <= (rx_sh == CHAR_CR);
          end
        end else rx_cnt <= rx_cnt - 16'h0001;
      endcase
    end
  end

  // Two-entry receive buffer between line and parser.
  logic [8:0] ent [2];
  logic [1:0] cnt;
  logic       rd;
  assign rd       = rx_valid && rx_ready;
  assign buf_full = (cnt == 2'h2);
  assign rx_valid = (cnt != 2'h0);
  assign rx_data  = ent[0][7:0];
  assign rx_line_end = ent[0][8];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt    <= 2'h0;
      ent[0] <= 9'h000;
      ent[1] <= 9'h000;
    end else begin
      if (rd) ent[0] <= ent[1];
      if (buf_wr) begin
        if (cnt == 2'h0 || (cnt == 2'h1 && rd)) ent[0] <= {buf_end, buf_d};
        else ent[1] <= {buf_end, buf_d};
      end
      cnt <= cnt + 2'(buf_wr) - 2'(rd);
    end
  end

  // Transmitter; after a byte flagged last it appends the terminator.
  phase_t      tx_ph;
  logic [15:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_sh;
  logic [1:0]  tx_pend;
  logic        tx_busy;
  assign tx_busy  = (tx_ph != IDLE);
  assign tx_ready = !tx_busy && tx_pend == 2'h0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ph   <= IDLE;
      tx_cnt  <= 16'h0000;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_pend <= 2'h0;
      txd     <= 1'b1;
    end else begin
      unique case (tx_ph)
        IDLE: begin
          if (tx_pend != 2'h0) begin // R7
            tx_sh   <= (tx_pend == 2'h2 || line_terminator == TERM_CR)
                       ? CHAR_CR : CHAR_LF;
            tx_pend <= tx_pend - 2'h1;
            tx_ph <= START;
            tx_cnt <= bit_div;
            txd   <= 1'b0;
          end else if (tx_valid) begin
            tx_sh  <= tx_data;
            tx_ph  <= START;
            tx_cnt <= bit_div;
            txd    <= 1'b0; // R10
            if (tx_last) begin // R7
              tx_pend <= (line_terminator == TERM_CRLF) ? 2'h2 : 2'h1;
            end
          end
        end
        START: if (tx_cnt == 16'h0000) begin
          tx_ph  <= DATA;
          tx_cnt <= bit_div;
          tx_bit <= 3'h0;
          txd    <= tx_sh[0];
          tx_sh  <= {1'b1, tx_sh[7:1]}; // R10
        end else tx_cnt <= tx_cnt - 16'h0001;
        DATA: if (tx_cnt == 16'h0000) begin
          tx_cnt <= bit_div;
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'(DATA_BITS - 1)) begin
            tx_ph <= STOP;
            txd   <= 1'b1; // R1
          end else begin
            txd   <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[7:1]};
          end
        end else tx_cnt <= tx_cnt - 16'h0001;
        STOP: if (tx_cnt == 16'h0000) tx_ph <= IDLE; // R1
        else tx_cnt <= tx_cnt - 16'h0001;
      endcase
    end
  end

  property p_lock_on_activity;
    @(posedge clk) disable iff (sys_rst) !rxd |=> key_lock;
  endproperty
  a_lock_on_activity: assert property (p_lock_on_activity) // R4
    else $error("keyboard not locked after line activity");

  property p_lock_sticks;
    @(posedge clk) disable iff (sys_rst) key_lock |=> key_lock;
  endproperty
  a_lock_sticks: assert property (p_lock_sticks) // R4
    else $error("keyboard lock dropped");

  property p_idle_unselected;
    @(posedge clk) disable iff (sys_rst)
      (remote_sel == IF_USB) |-> rs232_txd;
  endproperty
  a_idle_unselected: assert property (p_idle_unselected) // R3
    else $error("unselected transmitter active");

  property p_term_legal;
    @(posedge clk) disable iff (sys_rst) line_terminator != 2'h3;
  endproperty
  a_term_legal: assert property (p_term_legal) // R6
    else $error("illegal terminator code");

  property p_start_low;
    @(posedge clk) disable iff (sys_rst)
      (tx_ph == IDLE ##1 tx_ph == START) |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low) // R10
    else $error("start bit not low");

  property p_stop_high;
    @(posedge clk) disable iff (sys_rst) tx_ph == STOP |-> txd;
  endproperty
  a_stop_high: assert property (p_stop_high) // R1
    else $error("stop bit not high");

  property p_term_follows;
    @(posedge clk) disable iff (sys_rst)
      (tx_valid && tx_ready && tx_last) |=> tx_pend != 2'h0;
  endproperty
  a_term_follows: assert property (p_term_follows) // R7
    else $error("terminator not scheduled");

  property p_rate_fixed;
    @(posedge clk) disable iff (sys_rst)
      (tx_ph == START && $past(tx_ph) == IDLE) |-> tx_cnt == bit_div;
  endproperty
  a_rate_fixed: assert property (p_rate_fixed) // R2
    else $error("bit period not the selected rate");
endmodule : remote_serial_command_port

/* test/host_link.sv */
// Host side of one serial link: sends and receives 8N1 characters.
// Assumes one bit lasts bit_div+1 cycles of clk and the lines idle high.
module host_link (
  input  wire logic        clk,
  input  wire logic [31:0] bit_div,
  input  wire logic        dev_txd,
  output logic             host_txd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_txd = 1'b1;
  task automatic hold_bit(input logic v);
    host_txd = v;
    repeat (bit_div + 1) @(negedge clk);
  endtask : hold_bit
  task automatic send_byte(input logic [7:0] b);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(b[i]);
    hold_bit(1'b1);
  endtask : send_byte
  // A character whose stop bit is low, followed by one idle bit.
  task automatic send_bad(input logic [7:0] b);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(b[i]);
    hold_bit(1'b0);
    hold_bit(1'b1);
  endtask : send_bad
  // Counts the clock cycles for which a start bit stays low.
  task automatic time_start(output int n);
    n = 0;
    @(negedge dev_txd);
    @(negedge clk);
    while (dev_txd === 1'b0) begin
      n++;
      @(negedge clk);
    end
  endtask : time_start
  // Samples mid-bit, so a rate off by more than a few percent shows up.
  task automatic recv_byte(output logic [7:0] b, output logic stop);
    @(negedge dev_txd);
    repeat ((bit_div + 1) / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_div + 1) @(negedge clk);
      b[i] = dev_txd;
    end
    repeat (bit_div + 1) @(negedge clk);
    stop = dev_txd;
  endtask : recv_byte
endmodule : host_link

/* test/tb_remote_serial_command_port.sv */
// Bench for the serial command port with one host model on each line.
// Assumes the package constants and a 40 MHz clock.
module tb_remote_serial_command_port;
  import serial_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, sys_rst, remote_sel, term_wr, rx_ready;
  logic        tx_last, tx_valid, rs232_rxd, rs232_txd, usb_rxd, usb_txd;
  logic        rx_valid, rx_line_end, tx_ready, key_lock, rx_frame_err;
  logic [2:0]  baud_sel;
  logic [1:0]  term_sel, line_terminator;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] div;
  int          n_errors, samples_checked, cycles;
  remote_serial_command_port DUT (.clk(clk), .sys_rst(sys_rst),
    .baud_sel(baud_sel), .remote_sel(remote_sel), .term_wr(term_wr),
    .term_sel(term_sel), .rs232_rxd(rs232_rxd), .rs232_txd(rs232_txd),
    .usb_rxd(usb_rxd), .usb_txd(usb_txd), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_line_end(rx_line_end),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .line_terminator(line_terminator),
    .key_lock(key_lock), .rx_frame_err(rx_frame_err));
  host_link h232 (.clk(clk), .bit_div(div), .dev_txd(rs232_txd),
    .host_txd(rs232_rxd));
  host_link husb (.clk(clk), .bit_div(div), .dev_txd(usb_txd),
    .host_txd(usb_rxd));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic set_term(input logic [1:0] t, input logic [1:0] exp);
    term_sel = t;
    term_wr = 1'b1;
    @(negedge clk);
    term_wr = 1'b0;
    @(negedge clk);
    check({6'h0, line_terminator}, {6'h0, exp});
  endtask : set_term
  task automatic pop(input logic [7:0] exp, input logic last);
    check({7'h0, rx_valid}, 8'h01);
    check(rx_data, exp);
    check({7'h0, rx_line_end}, {7'h0, last});
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask : pop
  // The byte stays offered until the edge that sees tx_ready high.
  task automatic put(input logic [7:0] b, input logic last);
    tx_data = b;
    tx_last = last;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : put
  task automatic get(input logic usb, input logic [7:0] exp);
    logic [7:0] b;
    logic       s;
    if (usb) husb.recv_byte(b, s);
    else h232.recv_byte(b, s);
    check(b, exp);
    check({7'h0, s}, 8'h01);
    check({7'h0, usb ? rs232_txd : usb_txd}, 8'h01);
  endtask : get
  // Times one start bit at a slow rate, then drops back to 115200 so that
  // the rest of the character does not stretch the run.
  task automatic rate(input logic [2:0] sel, input int exp);
    int n;
    while (tx_ready !== 1'b1) @(negedge clk);
    baud_sel = sel;
    fork
      begin
        put(8'hff, 1'b0);
        @(negedge clk);
        baud_sel = BAUD_115200;
      end
      husb.time_start(n);
    join
    check(8'(n), 8'(exp));
    check(8'(n >> 8), 8'(exp >> 8));
  endtask : rate
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    sys_rst = 1'b1;
    {remote_sel, term_wr, rx_ready, tx_last, tx_valid} = 5'h0;
    baud_sel = BAUD_115200;
    term_sel = TERM_LF;
    tx_data = 8'h00;
    div = DIV_115200;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check({6'h0, line_terminator}, {6'h0, TERM_RESET});
    check({7'h0, key_lock}, 8'h00);
    check({7'h0, tx_ready}, 8'h01);
    $display("reset test done");
    h232.send_byte(8'h41);
    h232.send_byte(CHAR_LF);
    check({7'h0, key_lock}, 8'h01);
    check({7'h0, rx_frame_err}, 8'h00);
    pop(8'h41, 1'b0);
    pop(CHAR_LF, 1'b1);
    $display("receive test done");
    set_term(TERM_CRLF, TERM_CRLF);
    h232.send_bad(8'h5a);
    check({7'h0, rx_frame_err}, 8'h01);
    check({7'h0, rx_valid}, 8'h00);
    h232.send_byte(CHAR_CR);
    h232.send_byte(CHAR_LF);
    check({7'h0, rx_frame_err}, 8'h00);
    pop(CHAR_CR, 1'b0);
    pop(CHAR_LF, 1'b1);
    check({7'h0, rx_valid}, 8'h00);
    fork
      put(8'h55, 1'b1);
      begin
        get(1'b0, 8'h55);
        get(1'b0, CHAR_CR);
        get(1'b0, CHAR_LF);
      end
    join
    $display("crlf test done");
    remote_sel = IF_USB;
    baud_sel = BAUD_57600;
    div = DIV_57600;
    set_term(TERM_CR, TERM_CR);
    set_term(2'h3, TERM_CR);
    fork
      put(8'h31, 1'b1);
      begin
        get(1'b1, 8'h31);
        get(1'b1, CHAR_CR);
      end
    join
    $display("usb test done");
    rate(BAUD_1200, DIV_1200 + 1);
    rate(BAUD_9600, DIV_9600 + 1);
    rate(BAUD_38400, DIV_38400 + 1);
    $display("rate test done");
    stop_test();
  end
endmodule : tb_remote_serial_command_port
